// ===== rtl/tsc_regs.svh
// Register offsets, field positions, defaults and timing counts
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH
`define TSC_ADDR_STATUS   8'h00
`define TSC_ADDR_CTRL     8'h04
`define TSC_ADDR_WORD_A   8'h10
`define TSC_ADDR_WORD_D   8'h1C
`define TSC_CTRL_RESET    1'h0
`define TSC_RESP_OKAY     2'h0
`define TSC_RESP_DECERR   2'h3
`define TSC_STRAP_WAIT    2'h3
`define TSC_WORD_BITS     24
`define TSC_ADDR_HI       23
`define TSC_ADDR_LO       22
`define TSC_MODE_HI       11
`define TSC_MODE_LO       10
`define TSC_MODSEL_BIT    19
`define TSC_A_FIXED       12'h07C
`define TSC_B_FIXED       12'h73A
`define TSC_D_FIXED       5'h04
`define TSC_REF_868       10'h010
`define TSC_REF_433       10'h020
`define TSC_REF_915       10'h020
`define TSC_REF_315       10'h012
`define TSC_RXFB_868      17'h077F
`define TSC_RXFB_433      17'h0766
`define TSC_RXFB_915      17'h0FCF
`define TSC_RXFB_315      17'h02FE
`define TSC_TXFB_868      17'h0797
`define TSC_TXFB_433      17'h0796
`define TSC_TXFB_915      17'h0FFF
`define TSC_TXFB_315      17'h0319
`define TSC_CHI_868       5'h07
`define TSC_CHI_433       5'h02
`define TSC_CHI_915       5'h07
`define TSC_CHI_315       5'h00
`endif

// ===== rtl/tsc_pkg.sv
// Types shared by the transceiver control logic
package tsc_pkg;
  typedef enum logic [1:0] {mode_standby, mode_receive, mode_transmit, mode_idle} tsc_mode_type;
  typedef enum logic [1:0] {phase_wait, phase_standalone, phase_programmable} tsc_phase_type;
  typedef logic [21:0] tsc_payload_type;
endpackage

// ===== rtl/tsc_serial_if.sv
// Carrier between the top and the serial shifter
`timescale 1ns/1ps
`default_nettype none
interface tsc_serial_if;
  logic        enable;
  logic        sclk_rise;
  logic        sdata;
  logic        le_rise;
  logic [23:0] word;
  logic        word_strobe;
  modport ctrl    (output enable, output sclk_rise, output sdata, output le_rise,
                   input word, input word_strobe);
  modport shifter (input enable, input sclk_rise, input sdata, input le_rise,
                   output word, output word_strobe);
endinterface
`default_nettype wire

// ===== rtl/tsc_sync.sv
// Two-flop pin synchroniser with rising-edge detect
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] dly;
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    // Reset to low so undriven pins read as low
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        meta[i]    <= 1'b0;
        level_o[i] <= 1'b0;
        dly[i]     <= 1'b0;
      end else begin
        meta[i]    <= async_i[i];
        level_o[i] <= meta[i];
        dly[i]     <= level_o[i];
      end
    end
    assign rise_o[i] = level_o[i] & ~dly[i];
  end
endmodule
`default_nettype wire

// ===== rtl/tsc_shift.sv
// 24-bit serial shift register and latch strobe
`timescale 1ns/1ps
`default_nettype none
module tsc_shift (
  input  wire logic    sys_clk_i,
  input  wire logic    rst_i,
  tsc_serial_if.shifter bus
);
  logic [23:0] shreg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shreg           <= 24'h00_0000;
      bus.word        <= 24'h00_0000;
      bus.word_strobe <= 1'b0;
    end else begin
      if (bus.enable && bus.sclk_rise) begin
        shreg <= {shreg[22:0], bus.sdata};
      end
      if (bus.enable && bus.le_rise) begin
        bus.word <= shreg;
      end
      bus.word_strobe <= bus.enable & bus.le_rise;
    end
  end
  shift_in_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus.enable && bus.sclk_rise) |=> shreg[0] == $past(bus.sdata))
    else $error("shift register missed the data bit");
  shift_keep_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (bus.enable && bus.sclk_rise) |=> shreg[23:1] == $past(shreg[22:0]))
    else $error("shift register lost order");
endmodule
`default_nettype wire

// ===== rtl/tsc_top.sv
// Transceiver mode, strap and serial control logic with AXI4-Lite access
// Summary of operation
// - Amplitude keying: amplifier off while data XOR data_invert is low, on while it is high.
// - Frequency keying: low data XOR data_invert closes pulling switch, high opens it.
// - After reset start stand-alone, defaults chosen by both frequency-select pins.
// - Frequency-select pins pick one of four default channels.
// - Receive dividers default per channel.
// - Transmit dividers default per channel.
// - Stand-alone: enable pins give standby, receive, transmit or idle.
// - Undriven enable pins read low, so the device sits in standby.
// - Stand-alone: modulation pin picks keying, gain pin picks amplifier gain.
// - First change on frequency-select 0 enters programmable mode for good.
// - Each serial clock rise shifts the data bit into 24 bits.
// - Latch-enable rise copies shift register into one of four latches.
// - Word splits into two address bits and 22 payload bits.
// - Only the last 24 bits clocked in are kept.
// - A word updates only its addressed latch.
// - Serial port accepts words in standby and in active modes.
// - Latch contents survive mode changes.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.svh"
module tsc_top (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        tx_data_in_i,
  input  wire logic        freq_sel0_latch_enable_i,
  input  wire logic        freq_sel1_lock_indicator_i,
  input  wire logic        rx_enable_serial_clock_i,
  input  wire logic        tx_enable_serial_data_i,
  input  wire logic        modulation_select_i,
  input  wire logic        amp_gain_select_pin_i,
  output logic             pa_enable_o,
  output logic             pulling_switch_closed_o,
  output logic [1:0]       op_mode_o,
  output logic             fsk_select_o,
  output logic             amp_high_gain_o,
  output logic             prog_mode_o,
  output logic [9:0]       rx_ref_divider_o,
  output logic [16:0]      rx_feedback_divider_o,
  output logic [9:0]       tx_ref_divider_o,
  output logic [16:0]      tx_feedback_divider_o
);
  logic [6:0]                 pin_raw;
  logic [6:0]                 pin_sync;
  logic [6:0]                 pin_rise;
  logic                       s_txd;
  logic                       s_fs0;
  logic                       s_fs1;
  logic                       s_re;
  logic                       s_te;
  logic                       s_mod;
  logic                       s_gain;
  tsc_pkg::tsc_phase_type     phase;
  tsc_pkg::tsc_phase_type     next_phase;
  logic [1:0]                 strap_cnt;
  logic                       strap_load;
  logic                       fs0_strap;
  logic                       fs1_strap;
  logic                       prog;
  logic [1:0]                 fs_code;
  logic [9:0]                 def_rx_ref;
  logic [9:0]                 def_tx_ref;
  logic [16:0]                def_rx_fb;
  logic [16:0]                def_tx_fb;
  logic [4:0]                 def_c_hi;
  tsc_pkg::tsc_payload_type   def_word [4];
  tsc_pkg::tsc_payload_type   ctrl_word [4];
  logic [1:0]                 wr_index;
  tsc_pkg::tsc_payload_type   wr_payload;
  tsc_pkg::tsc_mode_type      cur_mode;
  logic                       cur_fsk;
  logic                       data_eff;
  logic                       next_pa;
  logic                       next_pull;
  logic                       data_invert;
  logic                       aw_held;
  logic                       w_held;
  logic [7:0]                 aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       aw_take;
  logic                       w_take;
  logic                       ar_take;
  logic                       wr_fire;
  logic                       next_aw_held;
  logic                       next_w_held;
  logic                       next_bvalid;
  logic                       next_rvalid;
  logic                       wr_mapped;
  logic                       rd_mapped;
  logic [31:0]                rd_value;
  logic [31:0]                status_word;
  tsc_serial_if               ser_bus ();

  assign pin_raw = {amp_gain_select_pin_i, modulation_select_i, tx_enable_serial_data_i,
                    rx_enable_serial_clock_i, freq_sel1_lock_indicator_i,
                    freq_sel0_latch_enable_i, tx_data_in_i};
  tsc_sync #(
    .WIDTH (7)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (pin_raw),
    .level_o   (pin_sync),
    .rise_o    (pin_rise)
  );
  assign s_txd  = pin_sync[0];
  assign s_fs0  = pin_sync[1];
  assign s_fs1  = pin_sync[2];
  assign s_re   = pin_sync[3];
  assign s_te   = pin_sync[4];
  assign s_mod  = pin_sync[5];
  assign s_gain = pin_sync[6];
  assign prog   = (phase == tsc_pkg::phase_programmable);

  assign ser_bus.enable    = prog;
  assign ser_bus.sclk_rise = pin_rise[3];
  assign ser_bus.sdata     = s_te;
  assign ser_bus.le_rise   = pin_rise[1];
  tsc_shift u_shift (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (ser_bus.shifter)
  );

  assign strap_load = (phase == tsc_pkg::phase_wait) && (strap_cnt == `TSC_STRAP_WAIT);
  always_comb begin
    next_phase = phase;
    case (phase)
      tsc_pkg::phase_wait: begin
        if (strap_load) next_phase = tsc_pkg::phase_standalone;
      end
      tsc_pkg::phase_standalone: begin
        if (s_fs0 != fs0_strap) next_phase = tsc_pkg::phase_programmable;
      end
      tsc_pkg::phase_programmable: next_phase = tsc_pkg::phase_programmable;
      default: next_phase = tsc_pkg::phase_wait;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase     <= tsc_pkg::phase_wait;
      strap_cnt <= 2'h0;
      fs0_strap <= 1'b0;
      fs1_strap <= 1'b0;
    end else begin
      phase <= next_phase;
      if (phase == tsc_pkg::phase_wait) strap_cnt <= strap_cnt + 2'h1;
      if (strap_load) begin
        fs0_strap <= s_fs0;
        fs1_strap <= s_fs1;
      end
    end
  end

  assign fs_code = {s_fs1, s_fs0};
  always_comb begin
    case (fs_code)
      2'h0: begin
        def_rx_ref = `TSC_REF_868;
        def_rx_fb  = `TSC_RXFB_868;
        def_tx_fb  = `TSC_TXFB_868;
        def_c_hi   = `TSC_CHI_868;
      end
      2'h1: begin
        def_rx_ref = `TSC_REF_433;
        def_rx_fb  = `TSC_RXFB_433;
        def_tx_fb  = `TSC_TXFB_433;
        def_c_hi   = `TSC_CHI_433;
      end
      2'h2: begin
        def_rx_ref = `TSC_REF_915;
        def_rx_fb  = `TSC_RXFB_915;
        def_tx_fb  = `TSC_TXFB_915;
        def_c_hi   = `TSC_CHI_915;
      end
      default: begin
        def_rx_ref = `TSC_REF_315;
        def_rx_fb  = `TSC_RXFB_315;
        def_tx_fb  = `TSC_TXFB_315;
        def_c_hi   = `TSC_CHI_315;
      end
    endcase
  end
  // Transmit reference equals the receive one on every channel
  assign def_tx_ref  = def_rx_ref;
  assign def_word[0] = {`TSC_A_FIXED, def_rx_ref};
  assign def_word[1] = {`TSC_B_FIXED, def_tx_ref};
  assign def_word[2] = {def_c_hi, def_rx_fb};
  assign def_word[3] = {`TSC_D_FIXED, def_tx_fb};

  assign wr_index   = ser_bus.word[`TSC_ADDR_HI:`TSC_ADDR_LO];
  assign wr_payload = ser_bus.word[`TSC_ADDR_LO-1:0];
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_latch
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        ctrl_word[gi] <= 22'h00_0000;
      end else if (strap_load) begin
        ctrl_word[gi] <= def_word[gi];
      end else if (prog && ser_bus.word_strobe && wr_index == 2'(gi)) begin
        ctrl_word[gi] <= wr_payload;
      end
    end
  end

  assign cur_mode = prog ? tsc_pkg::tsc_mode_type'(ctrl_word[0][`TSC_MODE_HI:`TSC_MODE_LO])
                  : (phase == tsc_pkg::phase_wait) ? tsc_pkg::mode_standby
                  : tsc_pkg::tsc_mode_type'({s_te, s_re});
  assign cur_fsk   = prog ? ctrl_word[0][`TSC_MODSEL_BIT] : s_mod;
  assign data_eff  = s_txd ^ data_invert;
  assign next_pa   = (cur_mode == tsc_pkg::mode_transmit) && (cur_fsk || data_eff);
  assign next_pull = (cur_mode == tsc_pkg::mode_transmit) && cur_fsk && !data_eff;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pa_enable_o             <= 1'b0;
      pulling_switch_closed_o <= 1'b0;
      op_mode_o               <= 2'h0;
      fsk_select_o            <= 1'b0;
      amp_high_gain_o         <= 1'b1;
      prog_mode_o             <= 1'b0;
      rx_ref_divider_o        <= 10'h000;
      rx_feedback_divider_o   <= 17'h0000;
      tx_ref_divider_o        <= 10'h000;
      tx_feedback_divider_o   <= 17'h0000;
    end else begin
      pa_enable_o             <= next_pa;
      pulling_switch_closed_o <= next_pull;
      op_mode_o               <= cur_mode;
      fsk_select_o            <= cur_fsk;
      amp_high_gain_o         <= !s_gain;
      prog_mode_o             <= prog;
      rx_ref_divider_o        <= ctrl_word[0][9:0];
      tx_ref_divider_o        <= ctrl_word[1][9:0];
      rx_feedback_divider_o   <= ctrl_word[2][16:0];
      tx_feedback_divider_o   <= ctrl_word[3][16:0];
    end
  end

  // Register slave: address and data held separately, so either may come first
  assign aw_take      = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take       = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_take      = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_fire      = aw_held && w_held && !s_axi_bvalid_o;
  assign next_aw_held = (aw_held && !wr_fire) || aw_take;
  assign next_w_held  = (w_held && !wr_fire) || w_take;
  assign next_bvalid  = wr_fire || (s_axi_bvalid_o && !s_axi_bready_i);
  assign next_rvalid  = ar_take || (s_axi_rvalid_o && !s_axi_rready_i);
  assign wr_mapped    = (aw_addr == `TSC_ADDR_STATUS) || (aw_addr == `TSC_ADDR_CTRL)
                     || (aw_addr[1:0] == 2'h0 && aw_addr >= `TSC_ADDR_WORD_A
                         && aw_addr <= `TSC_ADDR_WORD_D);
  assign rd_mapped    = (s_axi_araddr_i == `TSC_ADDR_STATUS)
                     || (s_axi_araddr_i == `TSC_ADDR_CTRL)
                     || (s_axi_araddr_i[1:0] == 2'h0 && s_axi_araddr_i >= `TSC_ADDR_WORD_A
                         && s_axi_araddr_i <= `TSC_ADDR_WORD_D);
  assign status_word  = {25'h000_0000, fs1_strap, fs0_strap, pa_enable_o, fsk_select_o,
                         op_mode_o, prog_mode_o};
  assign rd_value = !rd_mapped ? 32'h0000_0000
                  : (s_axi_araddr_i == `TSC_ADDR_STATUS) ? status_word
                  : (s_axi_araddr_i == `TSC_ADDR_CTRL) ? {31'h0000_0000, data_invert}
                  : {8'h00, s_axi_araddr_i[3:2], ctrl_word[s_axi_araddr_i[3:2]]};
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      data_invert     <= `TSC_CTRL_RESET;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `TSC_RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= `TSC_RESP_OKAY;
      s_axi_rdata_o   <= 32'h0000_0000;
    end else begin
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      s_axi_awready_o <= !next_aw_held && !next_bvalid;
      s_axi_wready_o  <= !next_w_held && !next_bvalid;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_arready_o <= !next_rvalid;
      if (aw_take) aw_addr <= s_axi_awaddr_i;
      if (w_take) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        s_axi_bresp_o <= wr_mapped ? `TSC_RESP_OKAY : `TSC_RESP_DECERR;
        if (aw_addr == `TSC_ADDR_CTRL && w_strb[0]) data_invert <= w_data[0];
      end
      if (ar_take) begin
        s_axi_rdata_o <= rd_value;
        s_axi_rresp_o <= rd_mapped ? `TSC_RESP_OKAY : `TSC_RESP_DECERR;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ask_pa_off_a: assert property (
    (cur_mode == tsc_pkg::mode_transmit && !cur_fsk && !data_eff) |=> !pa_enable_o)
    else $error("amplifier on during low data in amplitude keying");
  fsk_switch_a: assert property (
    (cur_fsk && data_eff) |=> !pulling_switch_closed_o)
    else $error("pulling switch closed on high data");
  start_standalone_a: assert property (
    (phase == tsc_pkg::phase_wait) |-> ##1 !prog_mode_o)
    else $error("programmable mode before strap");
  strap_default_a: assert property (
    (strap_load && fs_code == 2'h1) |=> ##1 (rx_feedback_divider_o == `TSC_RXFB_433))
    else $error("wrong receive feedback default");
  prog_entry_a: assert property (
    (phase == tsc_pkg::phase_standalone && s_fs0 != fs0_strap) |=> ##1 prog_mode_o)
    else $error("no programmable entry on select change");
  prog_sticky_a: assert property (
    prog |=> prog)
    else $error("left programmable mode");
  latch_load_a: assert property (
    (prog && ser_bus.word_strobe && wr_index == 2'h0) |=> ctrl_word[0] == $past(wr_payload))
    else $error("word a not loaded");
  latch_keep_a: assert property (
    (ser_bus.word_strobe && wr_index == 2'h0)
    |=> $stable(ctrl_word[1]) && $stable(ctrl_word[2]) && $stable(ctrl_word[3]))
    else $error("unaddressed latch changed");
  standalone_hold_a: assert property (
    (phase == tsc_pkg::phase_standalone) |=> $stable(ctrl_word[0]))
    else $error("latch changed in stand-alone mode");
  bresp_hold_a: assert property (
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  enter_prog_c: cover property ($rose(prog));
  word_write_c: cover property (prog && ser_bus.word_strobe);
  ask_tx_c: cover property (pa_enable_o && !fsk_select_o);
endmodule
`default_nettype wire

// ===== test/tsc_host_model.sv
// Host model driving the shared strap and three-wire serial pins
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
  input  wire logic sys_clk_i,
  output var logic  sclk_o,
  output var logic  sdata_o,
  output var logic  latch_en_o
);
  initial begin
    sclk_o = 1'h0;
    sdata_o = 1'h0;
    latch_en_o = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic set_pins(input logic fs0, input logic rx, input logic tx);
    @(posedge sys_clk_i);
    latch_en_o <= fs0;
    sclk_o <= rx;
    sdata_o <= tx;
  endtask
  task automatic enter_prog;
    @(posedge sys_clk_i);
    latch_en_o <= !latch_en_o;
    hold(10);
  endtask
  // Clock idles low between frames; 10 cycles a half period gives 80 ns
  task automatic send_word(input logic [23:0] w, input int extra);
    int i;
    @(posedge sys_clk_i);
    latch_en_o <= 1'h0;
    sclk_o <= 1'h0;
    hold(10);
    for (i = 23 + extra; i >= 0; i--) begin
      sdata_o <= (i > 23) ? 1'h1 : w[i];
      hold(10);
      sclk_o <= 1'h1;
      hold(10);
      sclk_o <= 1'h0;
    end
    hold(10);
    // Released data falls to the pull-down level
    sdata_o <= 1'h0;
    latch_en_o <= 1'h1;
    hold(10);
  endtask
endmodule
`default_nettype wire

// ===== test/tsc_top_tb_top.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/1ps
`default_nettype none
module tsc_top_tb_top;
  logic        sys_clk_i = 1'h0;
  logic        rst_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_data;
  logic [3:0]  s_axi_wstrb_i;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i, tx_data_in_i;
  logic        freq_sel1_lock_indicator_i, modulation_select_i;
  logic        amp_gain_select_pin_i;
  wire logic   freq_sel0_latch_enable_i, rx_enable_serial_clock_i, tx_enable_serial_data_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, pa_enable_o, pulling_switch_closed_o, fsk_select_o;
  logic        amp_high_gain_o, prog_mode_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, op_mode_o, rd_resp, wr_resp;
  logic [9:0]  rx_ref_divider_o, tx_ref_divider_o;
  logic [16:0] rx_feedback_divider_o, tx_feedback_divider_o;
  int          bad_count = 0, num_checks = 0;
  logic [9:0]  ref_t [4] = '{10'h010, 10'h020, 10'h020, 10'h012};
  logic [16:0] rxf_t [4] = '{17'h0_077f, 17'h0_0766, 17'h0_0fcf, 17'h0_02fe};
  logic [16:0] txf_t [4] = '{17'h0_0797, 17'h0_0796, 17'h0_0fff, 17'h0_0319};
  always #2 sys_clk_i = !sys_clk_i;
  tsc_host_model host (
    .sys_clk_i  (sys_clk_i),
    .sclk_o     (rx_enable_serial_clock_i),
    .sdata_o    (tx_enable_serial_data_i),
    .latch_en_o (freq_sel0_latch_enable_i)
  );
  tsc_top uut (.*);
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o) begin
        wr_resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'h0;
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o) begin
        rd_data = s_axi_rdata_o;
        rd_resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'h0;
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic do_reset(input logic f1, input logic f0);
    host.set_pins(f0, 1'h0, 1'h0);
    freq_sel1_lock_indicator_i <= f1;
    rst_i <= 1'h1;
    host.hold(12);
    rst_i <= 1'h0;
    host.hold(12);
  endtask
  task automatic test_straps;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1], k[0]);
      check(32'(prog_mode_o), 32'h0000_0000);
      check(32'(rx_ref_divider_o), 32'(ref_t[k]));
      check(32'(rx_feedback_divider_o), 32'(rxf_t[k]));
      check(32'(tx_ref_divider_o), 32'(ref_t[k]));
      check(32'(tx_feedback_divider_o), 32'(txf_t[k]));
    end
  endtask
  task automatic test_modes;
    do_reset(1'h0, 1'h0);
    check(32'(op_mode_o), 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      host.set_pins(1'h0, k[0], k[1]);
      host.hold(6);
      check(32'(op_mode_o), 32'(k));
    end
    host.set_pins(1'h0, 1'h0, 1'h1);
    for (int k = 0; k < 4; k++) begin
      modulation_select_i <= k[1];
      amp_gain_select_pin_i <= k[0] ^ k[1];
      tx_data_in_i <= k[0];
      host.hold(6);
      check(32'(fsk_select_o), 32'(k[1]));
      check(32'(amp_high_gain_o), 32'(!(k[0] ^ k[1])));
      check(32'(pa_enable_o), 32'(k[1] || k[0]));
      check(32'(pulling_switch_closed_o), 32'(k[1] && !k[0]));
    end
  endtask
  task automatic test_axi;
    modulation_select_i <= 1'h0;
    tx_data_in_i <= 1'h0;
    host.hold(6);
    check(32'(pa_enable_o), 32'h0000_0000);
    axi_read(8'h00);
    check(rd_data, 32'h0000_0004);
    axi_write(8'h04, 32'h0000_0001);
    check(32'(wr_resp), 32'h0000_0000);
    axi_read(8'h04);
    check(rd_data, 32'h0000_0001);
    // Lane 0 disabled: the invert bit must keep its value
    s_axi_wstrb_i <= 4'h0;
    axi_write(8'h04, 32'h0000_0000);
    check(32'(wr_resp), 32'h0000_0000);
    axi_read(8'h04);
    check(rd_data, 32'h0000_0001);
    s_axi_wstrb_i <= 4'hf;
    host.hold(6);
    check(32'(pa_enable_o), 32'h0000_0001);
    axi_write(8'h40, 32'hffff_ffff);
    check(32'(wr_resp), 32'h0000_0003);
    axi_read(8'h40);
    check({rd_data[29:0], rd_resp}, 32'h0000_0003);
    axi_write(8'h04, 32'h0000_0000);
  endtask
  task automatic test_serial;
    do_reset(1'h1, 1'h1);
    host.enter_prog();
    check(32'(prog_mode_o), 32'h0000_0001);
    host.send_word({2'h2, 22'h01_2345}, 4);
    host.hold(8);
    check(32'(rx_feedback_divider_o), 32'h0001_2345);
    check(32'(rx_ref_divider_o), 32'h0000_0012);
    axi_read(8'h18);
    check(rd_data, 32'h0081_2345);
    host.send_word({2'h0, 22'h00_0155}, 0);
    host.hold(8);
    check(32'(rx_ref_divider_o), 32'h0000_0155);
    host.send_word({2'h0, 22'h00_0555}, 0);
    host.hold(8);
    check(32'(op_mode_o), 32'h0000_0001);
    check(32'(rx_feedback_divider_o), 32'h0001_2345);
    check(32'(tx_feedback_divider_o), 32'h0000_0319);
    host.send_word({2'h1, 22'h00_03ff}, 0);
    host.send_word({2'h3, 22'h01_ffff}, 0);
    host.hold(8);
    check(32'(tx_ref_divider_o), 32'h0000_03ff);
    check(32'(tx_feedback_divider_o), 32'h0001_ffff);
    check(32'(rx_ref_divider_o), 32'h0000_0155);
    // Word A: frequency keying, transmit mode, same reference ratio
    host.send_word({2'h0, 22'h08_0955}, 0);
    host.hold(8);
    check(32'(op_mode_o), 32'h0000_0002);
    check(32'(fsk_select_o), 32'h0000_0001);
    check(32'(pulling_switch_closed_o), 32'h0000_0001);
    check(32'(pa_enable_o), 32'h0000_0001);
    tx_data_in_i <= 1'h1;
    host.hold(6);
    check(32'(pulling_switch_closed_o), 32'h0000_0000);
    check(32'(pa_enable_o), 32'h0000_0001);
  endtask
  initial begin
    rst_i = 1'h1;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'hf;
    s_axi_awvalid_i = 1'h0;
    s_axi_wvalid_i = 1'h0;
    s_axi_bready_i = 1'h0;
    s_axi_arvalid_i = 1'h0;
    s_axi_rready_i = 1'h0;
    tx_data_in_i = 1'h0;
    freq_sel1_lock_indicator_i = 1'h0;
    modulation_select_i = 1'h0;
    amp_gain_select_pin_i = 1'h0;
    test_straps();
    test_modes();
    test_axi();
    test_serial();
    test_done();
  end
endmodule
`default_nettype wire
